// ---- verification/wgc_bench.sv ----
// timer2_waveform_output_control_bench: register-driven checks of the waveform block.
// assumes TICK_DIV of 1, so the counter steps on every clock.
module timer2_waveform_output_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst = 1'h1;
  wgc_pkg::wgc_bus_req_t req = '0;
  logic [7:0] rdata;
  logic [7:0] cnt;
  logic pa_d = 1'h0;
  logic pa_dir = 1'h0;
  logic pb_d = 1'h0;
  logic pb_dir = 1'h0;
  logic a_o, a_oe_n, b_o, b_oe_n, a_cmp, b_cmp, irq, a_lvl, b_lvl, t;
  int err_total = 0;
  int n_checks = 0;

  always #2 clk = ~clk;

  wgc_timer_waveform #(.TICK_DIV(1)) i_dut (
    .clk(clk), .rst(rst), .bus_req(req), .bus_rdata(rdata),
    .chan_a_port_data(pa_d), .chan_a_port_dir(pa_dir),
    .chan_b_port_data(pb_d), .chan_b_port_dir(pb_dir),
    .chan_a_pin_o(a_o), .chan_a_pin_oe_n(a_oe_n),
    .chan_b_pin_o(b_o), .chan_b_pin_oe_n(b_oe_n),
    .chan_a_compare_out(a_cmp), .chan_b_compare_out(b_cmp),
    .timer_count_value(cnt), .irq(irq));

  wgc_pin_load i_load (.a_o(a_o), .a_oe_n(a_oe_n), .b_o(b_o), .b_oe_n(b_oe_n),
    .a_lvl(a_lvl), .b_lvl(b_lvl));

  // ==========================================================
  // access tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req.wr <= 1'h1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'h0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    req.rd <= 1'h1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'h0;
    #1 chk(rdata, exp);
  endtask : rd

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic setp(input logic [3:0] v);
    @(posedge clk);
    {pa_dir, pa_d, pb_dir, pb_d} <= v;
    step();
  endtask : setp

  // bounded wait for a count value; running out counts as a mismatch
  task automatic upto(input logic [7:0] v);
    int k;
    k = 0;
    #1;
    while (cnt !== v && k < 600)
    begin
      step();
      k++;
    end
    if (k == 600) chk(cnt, v);
  endtask : upto

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // ==========================================================
  // sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
  end

  initial
  begin
    #100000;
    err_total++;
    summarize();
  end

  initial
  begin
    @(negedge rst);
    rd(3'h0, 8'h00);
    wr(3'h0, 8'hFF);
    rd(3'h0, 8'hF3);
    rd(3'h7, 8'h00);
    rd(3'h1, 8'h00);
    wr(3'h0, 8'h00);
    // count write lands, then the next tick steps it
    wr(3'h2, 8'hF0);
    rd(3'h2, 8'hF1);
    setp(4'hB);
    step();
    chk(b_lvl, 8'h01);
    // normal mode, A toggles on match
    wr(3'h3, 8'h40);
    wr(3'h6, 8'h02);
    wr(3'h0, 8'h40);
    upto(8'h41);
    chk(a_cmp, 8'h01);
    chk(a_lvl, 8'h01);
    chk(irq, 8'h01);
    wr(3'h5, 8'h07);
    rd(3'h5, 8'h00);
    chk(irq, 8'h00);
    upto(8'h00);
    // b compare is 0 here, so the tick at 0 also flags match b
    rd(3'h5, 8'h05);
    upto(8'h41);
    chk(a_cmp, 8'h00);
    // clear-on-match mode, compare A is TOP
    wr(3'h4, 8'h10);
    wr(3'h0, 8'hF2);
    upto(8'h40);
    chk(b_cmp, 8'h01);
    step();
    chk(cnt, 8'h00);
    chk(a_cmp, 8'h01);
    wr(3'h0, 8'hA2);
    upto(8'h11);
    chk(b_cmp, 8'h00);
    upto(8'h00);
    chk(a_cmp, 8'h00);
    // fast pwm: A clears on match, B sets on match
    wr(3'h3, 8'h80);
    wr(3'h4, 8'h20);
    wr(3'h0, 8'hB3);
    upto(8'h81);
    chk(a_cmp, 8'h00);
    chk(b_cmp, 8'h01);
    upto(8'h01);
    chk(a_cmp, 8'h01);
    chk(b_cmp, 8'h00);
    // new value must wait for TOP
    wr(3'h3, 8'h90);
    upto(8'h81);
    chk(a_cmp, 8'h00);
    upto(8'h01);
    upto(8'h81);
    chk(a_cmp, 8'h01);
    wr(3'h4, 8'hFF);
    wr(3'h0, 8'hA3);
    upto(8'h01);
    upto(8'h80);
    chk(b_cmp, 8'h01);
    // code 01 with top bit clear leaves the port in charge
    setp(4'hA);
    wr(3'h0, 8'h63);
    rd(3'h0, 8'h63);
    chk(a_lvl, 8'h00);
    // fast pwm with compare A as TOP, A toggles
    wr(3'h1, 8'h08);
    upto(8'h90);
    step();
    chk(cnt, 8'h00);
    t = a_cmp;
    wr(3'h5, 8'h07);
    upto(8'h90);
    step();
    rd(3'h5, 8'h03);
    chk(a_cmp, {7'h00, ~t});
    // phase correct: A clears going up, B sets going up
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h40);
    wr(3'h4, 8'h20);
    wr(3'h0, 8'hB1);
    upto(8'hFF);
    step();
    chk(cnt, 8'hFE);
    upto(8'h1F);
    chk(a_cmp, 8'h01);
    chk(b_cmp, 8'h00);
    upto(8'h41);
    chk(a_cmp, 8'h00);
    chk(b_cmp, 8'h01);
    // reserved mode 4 holds a written count
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h08);
    wr(3'h2, 8'h55);
    rd(3'h2, 8'h55);
    summarize();
  end
endmodule : timer2_waveform_output_control_bench

// ---- verification/wgc_pin_load.sv ----
// wgc_pin_load: load hanging on the two compare pins, seen as wire levels.
// assumes a pull-down on each pin, so a released pin reads low.
module wgc_pin_load (
  // pins from the block
  input wire logic a_o,
  input wire logic a_oe_n,
  input wire logic b_o,
  input wire logic b_oe_n,
  // levels seen by the load
  output logic a_lvl,
  output logic b_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  assign a_lvl = a_oe_n ? 1'h0 : a_o;
  assign b_lvl = b_oe_n ? 1'h0 : b_o;
endmodule : wgc_pin_load

// ---- verilog/wgc_pkg.sv ----
// wgc_pkg: constants, types and register map of the timer waveform block.
// assumes one 250 MHz clock; software reaches the map over a plain strobe port.

package wgc_pkg;

  // ==========================================================
  // bus widths and register map
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] REG_CTRL_FIRST = 3'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL_SECOND = 3'h1;
  localparam logic [ADDR_W-1:0] REG_COUNT = 3'h2;
  localparam logic [ADDR_W-1:0] REG_CMP_A = 3'h3;
  localparam logic [ADDR_W-1:0] REG_CMP_B = 3'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 3'h5;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 3'h6;

  // ==========================================================
  // field positions and reset values
  localparam int CTRL2_TOP_BIT_POS = 3;
  localparam int STAT_W = 3;
  localparam int STAT_OVF = 0;
  localparam int STAT_MATCH_A = 1;
  localparam int STAT_MATCH_B = 2;

  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_MAX = 8'hFF;
  localparam logic [DATA_W-1:0] COUNT_BOTTOM = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_STEP = 8'h01;
  localparam logic [DATA_W-1:0] CMP_RESET = 8'h00;
  localparam logic [STAT_W-1:0] STAT_RESET = 3'h0;
  localparam logic [15:0] DIV_ZERO = 16'h0000;
  localparam logic [15:0] DIV_STEP = 16'h0001;

  // ==========================================================
  // modes
  typedef enum logic [2:0] {
    WM_NORMAL = 3'b000,
    WM_PHASE_FF = 3'b001,
    WM_CLEAR_ON_MATCH = 3'b010,
    WM_FAST_FF = 3'b011,
    WM_RSVD_4 = 3'b100,
    WM_PHASE_CMP = 3'b101,
    WM_RSVD_6 = 3'b110,
    WM_FAST_CMP = 3'b111
  } wgc_wave_mode_t;

  typedef enum logic [1:0] {
    OM_DISCONNECT = 2'b00,
    OM_TOGGLE = 2'b01,
    OM_CLEAR = 2'b10,
    OM_SET = 2'b11
  } wgc_out_mode_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [1:0] chan_a_output_mode;
    logic [1:0] chan_b_output_mode;
    logic [1:0] reserved;
    logic [1:0] waveform_mode_low_bits;
  } wgc_ctrl_first_t;

  localparam wgc_ctrl_first_t CTRL_FIRST_RESET = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } wgc_bus_req_t;

endpackage : wgc_pkg

// ---- verilog/wgc_timer_waveform.sv ----
// wgc_timer_waveform: 8-bit timer with two compare channels and waveform output.
// assumes inputs synchronous to clk; port data/direction come from the port block.
//
// Functional notes
// - nonzero output-mode code makes the compare output take over the pin, except A code 01 in PWM with mode top bit 0.
// - non-PWM codes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - fast PWM A: 10 clear on match set at TOP, 11 reverse, 00 off.
// - PWM A code 01: off when mode top bit 0, toggle on match when 1.
// - phase PWM A: 10 clears on up match, sets on down match; 11 reverse.
// - fast PWM B: 10 clear match set TOP, 11 reverse, 01 reserved, 00 off.
// - phase PWM B: 10 clear up match, set down match; 11 reverse; 01 reserved.
// - PWM with compare equal TOP and code bit1 set: act at TOP, ignore match.
// - bits 3 and 2 of the first control register read as zero.
// - mode is top bit from second control register plus two low bits.
// - modes 0,1,2,3,5,7 as normal/phase/clear/fast; 4 and 6 reserved.
// - TOP is 0xFF in modes 0,1,3 and compare A in modes 2,5,7.
// - compare values immediate in non-PWM, double-buffered to TOP in PWM.
// - overflow at MAX in 0,2,3; at BOTTOM in 1,5; at TOP in 7.
// - supports normal, clear-on-match, fast PWM and phase-correct PWM.
// - phase-correct counts up to TOP then down to BOTTOM repeatedly.
//
// The register offsets and the strobed register port were chosen for this implementation.

module wgc_timer_waveform #(
  parameter int unsigned TICK_DIV = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire wgc_pkg::wgc_bus_req_t bus_req,
  output logic [wgc_pkg::DATA_W-1:0] bus_rdata,
  // normal port function behind each pin
  input wire logic chan_a_port_data,
  input wire logic chan_a_port_dir,
  input wire logic chan_b_port_data,
  input wire logic chan_b_port_dir,
  // pins
  output logic chan_a_pin_o,
  output logic chan_a_pin_oe_n,
  output logic chan_b_pin_o,
  output logic chan_b_pin_oe_n,
  // raw compare outputs and counter
  output logic chan_a_compare_out,
  output logic chan_b_compare_out,
  output logic [wgc_pkg::DATA_W-1:0] timer_count_value,
  // interrupt
  output logic irq
);

  // ==========================================================
  // helpers
  function automatic logic is_fast(input wgc_pkg::wgc_wave_mode_t m);
    is_fast = (m == wgc_pkg::WM_FAST_FF) || (m == wgc_pkg::WM_FAST_CMP);
  endfunction : is_fast

  function automatic logic is_phase(input wgc_pkg::wgc_wave_mode_t m);
    is_phase = (m == wgc_pkg::WM_PHASE_FF) || (m == wgc_pkg::WM_PHASE_CMP);
  endfunction : is_phase

  function automatic logic is_nonpwm(input wgc_pkg::wgc_wave_mode_t m);
    is_nonpwm = (m == wgc_pkg::WM_NORMAL) || (m == wgc_pkg::WM_CLEAR_ON_MATCH);
  endfunction : is_nonpwm

  function automatic logic wr_hit(input wgc_pkg::wgc_bus_req_t r,
                                  input logic [wgc_pkg::ADDR_W-1:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction : wr_hit

  // takeover; A code 01 in PWM needs the mode top bit
  function automatic logic takes_pin(input logic [1:0] code,
                                     input wgc_pkg::wgc_wave_mode_t m,
                                     input logic is_b);
    takes_pin = (code != wgc_pkg::OM_DISCONNECT) &&
                !(!is_b && code == wgc_pkg::OM_TOGGLE && !is_nonpwm(m) && !m[2]);
  endfunction : takes_pin

  // next compare output level for one channel
  function automatic logic out_next(
    input logic cur,
    input logic [1:0] code,
    input wgc_pkg::wgc_wave_mode_t m,
    input logic is_b,
    input logic match,
    input logic top_evt,
    input logic up,
    input logic cmp_is_top
  );
    logic act;
    act = (code == wgc_pkg::OM_SET);
    out_next = cur;
    if (is_nonpwm(m))
    begin
      if (match && code == wgc_pkg::OM_TOGGLE)
        out_next = ~cur;
      else if (match && code[1])
        out_next = act;
    end
    else if (is_fast(m))
    begin
      // toggle only on A with top bit set; B code 01 does nothing
      if (code == wgc_pkg::OM_TOGGLE)
      begin
        if (!is_b && m[2] && match)
          out_next = ~cur;
      end
      // top action wins, match at TOP ignored
      else if (code[1] && top_evt)
        out_next = ~act;
      else if (code[1] && match && !cmp_is_top)
        out_next = act;
    end
    else if (is_phase(m))
    begin
      if (code == wgc_pkg::OM_TOGGLE)
      begin
        if (!is_b && m[2] && match)
          out_next = ~cur;
      end
      // compare at TOP acts at TOP as if down-counting
      else if (code[1] && match && cmp_is_top)
        out_next = ~act;
      else if (code[1] && match)
        out_next = up ? act : ~act;
    end
  endfunction : out_next

  // ==========================================================
  // registers and state
  wgc_pkg::wgc_ctrl_first_t ctrl_first_reg;
  logic waveform_mode_top_bit_reg;
  logic [wgc_pkg::DATA_W-1:0] count_reg;
  logic [wgc_pkg::DATA_W-1:0] cmp_a_buf_reg;
  logic [wgc_pkg::DATA_W-1:0] cmp_b_buf_reg;
  logic [wgc_pkg::DATA_W-1:0] cmp_a_act_reg;
  logic [wgc_pkg::DATA_W-1:0] cmp_b_act_reg;
  logic [wgc_pkg::STAT_W-1:0] status_reg;
  logic [wgc_pkg::STAT_W-1:0] mask_reg;
  logic [wgc_pkg::DATA_W-1:0] rdata_reg;
  logic [15:0] div_reg;
  logic dir_up_reg;
  logic block_reg;
  logic a_out_reg;
  logic b_out_reg;
  logic a_pin_reg;
  logic b_pin_reg;
  logic a_oe_n_reg;
  logic b_oe_n_reg;

  wgc_pkg::wgc_wave_mode_t waveform_mode_field;
  logic [wgc_pkg::DATA_W-1:0] top_val;
  logic tick;
  logic top_tick;
  logic pwm;
  logic match_a;
  logic match_b;
  logic ovf_evt;
  logic a_out_next;
  logic b_out_next;
  logic [wgc_pkg::STAT_W-1:0] events;
  logic [wgc_pkg::DATA_W-1:0] rdata_next;

  // ==========================================================
  // mode decode
  // mode assembly
  assign waveform_mode_field =
    wgc_pkg::wgc_wave_mode_t'({waveform_mode_top_bit_reg, ctrl_first_reg.waveform_mode_low_bits});
  assign pwm = is_fast(waveform_mode_field) || is_phase(waveform_mode_field);

  assign top_val = (waveform_mode_field == wgc_pkg::WM_CLEAR_ON_MATCH ||
                    waveform_mode_field == wgc_pkg::WM_PHASE_CMP ||
                    waveform_mode_field == wgc_pkg::WM_FAST_CMP) ? cmp_a_act_reg
                                                                 : wgc_pkg::COUNT_MAX;

  // ==========================================================
  // timer tick divider
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div_reg <= wgc_pkg::DIV_ZERO;
    else if (tick)
      div_reg <= wgc_pkg::DIV_ZERO;
    else
      div_reg <= div_reg + wgc_pkg::DIV_STEP;
  end

  assign tick = (div_reg >= 16'(TICK_DIV - 1));
  assign top_tick = tick && (count_reg == top_val);

  // ==========================================================
  // compare and overflow events
  // match on tick, suppressed after a count write
  assign match_a = tick && !block_reg && (count_reg == cmp_a_act_reg);
  assign match_b = tick && !block_reg && (count_reg == cmp_b_act_reg);

  always_comb
  begin
    ovf_evt = 1'b0;
    unique case (waveform_mode_field)
      wgc_pkg::WM_NORMAL, wgc_pkg::WM_CLEAR_ON_MATCH, wgc_pkg::WM_FAST_FF:
        ovf_evt = tick && (count_reg == wgc_pkg::COUNT_MAX);
      wgc_pkg::WM_PHASE_FF, wgc_pkg::WM_PHASE_CMP:
        ovf_evt = tick && (count_reg == wgc_pkg::COUNT_BOTTOM);
      wgc_pkg::WM_FAST_CMP:
        ovf_evt = top_tick;
      wgc_pkg::WM_RSVD_4, wgc_pkg::WM_RSVD_6:
        ovf_evt = 1'b0;
    endcase
  end

  // ==========================================================
  // counter and direction
  // count sequence per mode; reserved modes hold the count
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count_reg <= wgc_pkg::COUNT_BOTTOM;
    else if (wr_hit(bus_req, wgc_pkg::REG_COUNT))
      count_reg <= bus_req.wdata;
    else if (tick)
    begin
      unique case (waveform_mode_field)
        wgc_pkg::WM_NORMAL:
          count_reg <= 8'(count_reg + wgc_pkg::COUNT_STEP);
        wgc_pkg::WM_CLEAR_ON_MATCH, wgc_pkg::WM_FAST_FF, wgc_pkg::WM_FAST_CMP:
          count_reg <= top_tick ? wgc_pkg::COUNT_BOTTOM
                                : 8'(count_reg + wgc_pkg::COUNT_STEP);
        wgc_pkg::WM_PHASE_FF, wgc_pkg::WM_PHASE_CMP:
          if (dir_up_reg ? (count_reg >= top_val && count_reg != wgc_pkg::COUNT_BOTTOM)
                         : (count_reg != wgc_pkg::COUNT_BOTTOM))
            count_reg <= 8'(count_reg - wgc_pkg::COUNT_STEP);
          else if (count_reg != top_val)
            count_reg <= 8'(count_reg + wgc_pkg::COUNT_STEP);
        wgc_pkg::WM_RSVD_4, wgc_pkg::WM_RSVD_6:
          count_reg <= count_reg;
      endcase
    end
  end

  // turn at TOP, turn back at BOTTOM
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dir_up_reg <= 1'b1;
    else if (!is_phase(waveform_mode_field))
      dir_up_reg <= 1'b1;
    else if (tick && dir_up_reg && count_reg >= top_val)
      dir_up_reg <= 1'b0;
    else if (tick && !dir_up_reg && count_reg == wgc_pkg::COUNT_BOTTOM)
      dir_up_reg <= 1'b1;
  end

  // a count write blocks the match on the following tick
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      block_reg <= 1'b0;
    else if (wr_hit(bus_req, wgc_pkg::REG_COUNT))
      block_reg <= 1'b1;
    else if (tick)
      block_reg <= 1'b0;
  end

  // ==========================================================
  // compare registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmp_a_buf_reg <= wgc_pkg::CMP_RESET;
      cmp_b_buf_reg <= wgc_pkg::CMP_RESET;
    end
    else
    begin
      if (wr_hit(bus_req, wgc_pkg::REG_CMP_A))
        cmp_a_buf_reg <= bus_req.wdata;
      if (wr_hit(bus_req, wgc_pkg::REG_CMP_B))
        cmp_b_buf_reg <= bus_req.wdata;
    end
  end

  // immediate outside PWM, loaded at TOP inside PWM
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmp_a_act_reg <= wgc_pkg::CMP_RESET;
      cmp_b_act_reg <= wgc_pkg::CMP_RESET;
    end
    else
    begin
      if (!pwm && wr_hit(bus_req, wgc_pkg::REG_CMP_A))
        cmp_a_act_reg <= bus_req.wdata;
      else if (!pwm || top_tick)
        cmp_a_act_reg <= cmp_a_buf_reg;
      if (!pwm && wr_hit(bus_req, wgc_pkg::REG_CMP_B))
        cmp_b_act_reg <= bus_req.wdata;
      else if (!pwm || top_tick)
        cmp_b_act_reg <= cmp_b_buf_reg;
    end
  end

  // ==========================================================
  // waveform outputs and pin takeover
  assign a_out_next = out_next(a_out_reg, ctrl_first_reg.chan_a_output_mode,
                               waveform_mode_field, 1'b0, match_a, top_tick, dir_up_reg,
                               cmp_a_act_reg == top_val);
  assign b_out_next = out_next(b_out_reg, ctrl_first_reg.chan_b_output_mode,
                               waveform_mode_field, 1'b1, match_b, top_tick, dir_up_reg,
                               cmp_b_act_reg == top_val);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      a_out_reg <= 1'b0;
      b_out_reg <= 1'b0;
    end
    else
    begin
      a_out_reg <= a_out_next;
      b_out_reg <= b_out_next;
    end
  end

  // takeover per code and mode; pin registered with the output
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      a_pin_reg <= 1'b0;
      b_pin_reg <= 1'b0;
    end
    else
    begin
      a_pin_reg <= takes_pin(ctrl_first_reg.chan_a_output_mode, waveform_mode_field, 1'b0) ?
                   a_out_next : chan_a_port_data;
      b_pin_reg <= takes_pin(ctrl_first_reg.chan_b_output_mode, waveform_mode_field, 1'b1) ?
                   b_out_next : chan_b_port_data;
    end
  end

  // driver follows the port direction bit only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      a_oe_n_reg <= 1'b1;
      b_oe_n_reg <= 1'b1;
    end
    else
    begin
      a_oe_n_reg <= ~chan_a_port_dir;
      b_oe_n_reg <= ~chan_b_port_dir;
    end
  end

  // ==========================================================
  // control and interrupt registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_first_reg <= wgc_pkg::CTRL_FIRST_RESET;
      waveform_mode_top_bit_reg <= 1'b0;
      mask_reg <= wgc_pkg::STAT_RESET;
    end
    else
    begin
      if (wr_hit(bus_req, wgc_pkg::REG_CTRL_FIRST))
      begin
        ctrl_first_reg <= bus_req.wdata;
        ctrl_first_reg.reserved <= 2'b00;
      end
      if (wr_hit(bus_req, wgc_pkg::REG_CTRL_SECOND))
        waveform_mode_top_bit_reg <= bus_req.wdata[wgc_pkg::CTRL2_TOP_BIT_POS];
      if (wr_hit(bus_req, wgc_pkg::REG_IRQ_MASK))
        mask_reg <= bus_req.wdata[wgc_pkg::STAT_W-1:0];
    end
  end

  assign events = {match_b, match_a, ovf_evt};

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      status_reg <= wgc_pkg::STAT_RESET;
    else if (wr_hit(bus_req, wgc_pkg::REG_IRQ_STATUS))
      status_reg <= (status_reg & ~bus_req.wdata[wgc_pkg::STAT_W-1:0]) | events;
    else
      status_reg <= status_reg | events;
  end

  // ==========================================================
  // read path, one cycle latency, unmapped reads zero
  always_comb
  begin
    rdata_next = wgc_pkg::DATA_ZERO;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        wgc_pkg::REG_CTRL_FIRST:
          rdata_next = ctrl_first_reg;
        wgc_pkg::REG_CTRL_SECOND:
          rdata_next[wgc_pkg::CTRL2_TOP_BIT_POS] = waveform_mode_top_bit_reg;
        wgc_pkg::REG_COUNT:
          rdata_next = count_reg;
        wgc_pkg::REG_CMP_A:
          rdata_next = cmp_a_buf_reg;
        wgc_pkg::REG_CMP_B:
          rdata_next = cmp_b_buf_reg;
        wgc_pkg::REG_IRQ_STATUS:
          rdata_next[wgc_pkg::STAT_W-1:0] = status_reg;
        wgc_pkg::REG_IRQ_MASK:
          rdata_next[wgc_pkg::STAT_W-1:0] = mask_reg;
        default:
          rdata_next = wgc_pkg::DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= wgc_pkg::DATA_ZERO;
    else
      rdata_reg <= rdata_next;
  end

  assign bus_rdata = rdata_reg;
  assign chan_a_pin_o = a_pin_reg;
  assign chan_b_pin_o = b_pin_reg;
  assign chan_a_pin_oe_n = a_oe_n_reg;
  assign chan_b_pin_oe_n = b_oe_n_reg;
  assign chan_a_compare_out = a_out_reg;
  assign chan_b_compare_out = b_out_reg;
  assign timer_count_value = count_reg;
  assign irq = |(status_reg & mask_reg);

  // ==========================================================
  // assertions
  property p_pin_takeover;
    @(posedge clk) disable iff (rst)
    takes_pin(ctrl_first_reg.chan_a_output_mode, waveform_mode_field, 1'b0)
    |=> chan_a_pin_o == a_out_reg;
  endproperty
  a_pin_takeover: assert property (p_pin_takeover) else $error("pin not taken over");

  property p_nonpwm_toggle;
    @(posedge clk) disable iff (rst)
    is_nonpwm(waveform_mode_field) && match_a &&
    ctrl_first_reg.chan_a_output_mode == wgc_pkg::OM_TOGGLE |=> a_out_reg != $past(a_out_reg);
  endproperty
  a_nonpwm_toggle: assert property (p_nonpwm_toggle) else $error("no toggle on match");

  property p_fast_top_set;
    @(posedge clk) disable iff (rst)
    is_fast(waveform_mode_field) && top_tick &&
    ctrl_first_reg.chan_a_output_mode == wgc_pkg::OM_CLEAR |=> a_out_reg;
  endproperty
  a_fast_top_set: assert property (p_fast_top_set) else $error("not set at top");

  property p_phase_up_clear;
    @(posedge clk) disable iff (rst)
    is_phase(waveform_mode_field) && match_a && dir_up_reg && cmp_a_act_reg != top_val &&
    ctrl_first_reg.chan_a_output_mode == wgc_pkg::OM_CLEAR |=> !a_out_reg;
  endproperty
  a_phase_up_clear: assert property (p_phase_up_clear) else $error("up match not cleared");

  property p_b_reserved;
    @(posedge clk) disable iff (rst)
    pwm && ctrl_first_reg.chan_b_output_mode == wgc_pkg::OM_TOGGLE |=> $stable(b_out_reg);
  endproperty
  a_b_reserved: assert property (p_b_reserved) else $error("b code 01 moved output");

  property p_rsvd_read;
    @(posedge clk) disable iff (rst)
    bus_req.rd && bus_req.addr == wgc_pkg::REG_CTRL_FIRST |=> bus_rdata[3:2] == 2'b00;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits nonzero");

  property p_top_ff;
    @(posedge clk) disable iff (rst)
    waveform_mode_field == wgc_pkg::WM_FAST_FF |-> top_val == wgc_pkg::COUNT_MAX;
  endproperty
  a_top_ff: assert property (p_top_ff) else $error("top not 0xFF");

  property p_double_buffer;
    @(posedge clk) disable iff (rst)
    pwm && !top_tick |=> cmp_a_act_reg == $past(cmp_a_act_reg);
  endproperty
  a_double_buffer: assert property (p_double_buffer) else $error("compare changed off top");

  property p_ovf_bottom;
    @(posedge clk) disable iff (rst)
    is_phase(waveform_mode_field) && tick && count_reg == wgc_pkg::COUNT_BOTTOM
    |=> status_reg[wgc_pkg::STAT_OVF];
  endproperty
  a_ovf_bottom: assert property (p_ovf_bottom) else $error("overflow missed at bottom");

  property p_phase_up;
    @(posedge clk) disable iff (rst)
    is_phase(waveform_mode_field) && tick && dir_up_reg && count_reg < top_val &&
    !bus_req.wr |=> count_reg == $past(count_reg) + 8'h01;
  endproperty
  a_phase_up: assert property (p_phase_up) else $error("phase count did not rise");

  property p_match_flag;
    @(posedge clk) disable iff (rst)
    tick && !block_reg && count_reg == cmp_b_act_reg |=> status_reg[wgc_pkg::STAT_MATCH_B];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match b flag missing");

endmodule : wgc_timer_waveform
